// ===== rtl/adc_cmd_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts of the command path.
// Assumes: 40 MHz system clock; 16-bit command and register words.
// Notes:   Definitions only.
`ifndef ADC_CMD_CONSTS_SVH
`define ADC_CMD_CONSTS_SVH
// ==========================================================================
// Command words and answer words
`define CMD_NULL        16'h0000
`define CMD_RESET       16'h0011
`define CMD_STANDBY     16'h0022
`define CMD_WAKEUP      16'h0033
`define CMD_LOCK        16'h0555
`define CMD_UNLOCK      16'h0655
`define PFX_REGISTER_READ_CMD        3'h5
`define PFX_REGISTER_WRITE_CMD        3'h3
`define PFX_REGISTER_READ_CMD_HDR    3'h7
`define PFX_REGISTER_WRITE_CMD_ACK    3'h2
`define RSP_RESET_ACK   16'hFF28
`define RSP_RESET_SHORT 16'h0011
// ==========================================================================
// Register addresses, reset values and fields
`define ADDR_ID         6'h00
`define ADDR_STATUS     6'h01
`define ADDR_MODE       6'h02
`define ADDR_CLOCK      6'h03
`define REG_LAST        6'h3E
`define MODE_RESET      16'h0510
`define CLOCK_RESET     16'hFF0E
`define MODE_FMT_BIT    0
`define MODE_RST_BIT    10
`define WSEL_16         2'h0
`define WSEL_24         2'h1
`define WSEL_32_PAD     2'h2
`define WSEL_32_SEXT    2'h3
`define CODE_MAX        24'h7FFFFF
`define CODE_MIN        24'h800000
`define FRAME_WORDS     8'h0A
// ==========================================================================
// Timing
`define CLK_PERIOD_NS   25
`define READY_PULSE_NS  50
`define READY_PULSE_CYC ((`READY_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== rtl/adc_cmd_pkg.sv
// Purpose: Types shared by the command path.
// Assumes: Constants come from adc_cmd_consts.svh.
// Notes:   Types only.
package adc_cmd_pkg;
   // ==========================================================================
   // Kinds of first answer word.
   typedef enum logic [1:0] {RSP_STATUS, RSP_FIXED, RSP_REG} rsp_kind_t;
   // Decoded command classes after lock filtering.
   typedef enum logic [2:0] {
      K_NULL, K_RESET, K_STANDBY, K_WAKEUP, K_LOCK, K_UNLOCK, K_REGISTER_READ_CMD, K_REGISTER_WRITE_CMD
   } cmd_kind_t;
endpackage

// ===== rtl/adc_spi_cmd.sv
// Purpose: Serial command interpreter and conversion data output path.
// Assumes: Host drives SCLK idle low, launches on rising and samples on falling edges.
// Notes:   Frame CRC is sent as a zero word; CRC checking is not provided.
// Overview of operation
// - Clip results to largest and most negative code.
// - Results are 24-bit two's complement.
// - FIFO holds two samples per channel.
// - Ready flag holds until both samples read.
// - Sync strobe empties FIFOs and realigns conversions.
// - Narrow ready pulse may occur; host ignores.
// - Null command changes nothing, answers status.
// - Invalid command behaves as null command.
// - Full reset frame resets registers, answers acknowledge.
// - Short reset frame answers distinct word.
// - Standby latched at frame end, echoed.
// - Wakeup returns to conversion, echoed.
// - Lock allows only null, read, unlock.
// - Unlock leaves locked state, echoed.
// - Read command: prefix, address, count minus one.
// - Single read answers register contents directly.
// - Multiple read answers header then registers ascending.
// - Write answers prefix, address, written count minus one.
// - Answer comes in the following frame.
// - Sixteen bits MSB aligned, low bits zero.
// - Read-only and out-of-range writes ignored, not counted.
//
// Local design decisions: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "adc_cmd_consts.svh"

module adc_spi_cmd
   import adc_cmd_pkg::*;
#(
   parameter int          NCH      = 8,
   parameter int          CONV_W   = 26,
   parameter logic [15:0] ID_VALUE = 16'h0800  // Arbitrary identity value.
)
(
   // Clock and reset
   input  wire logic                  i_clk,
   input  wire logic                  i_rst_n,
   // Serial link pins
   input  wire logic                  i_sclk,
   input  wire logic                  i_cs_n,
   input  wire logic                  i_din,
   output logic                       o_dout,
   output logic                       o_dout_oe,
   output logic                       o_data_ready_n,
   input  wire logic                  i_sync_rst_n,
   // Conversion results from the modulators and filters
   input  wire logic                  i_conv_valid,
   input  wire logic [NCH*CONV_W-1:0] i_conv_data,
   // Device state
   output logic                       o_standby,
   output logic                       o_realign,
   // Register port
   input  wire logic [5:0]            i_reg_addr,
   input  wire logic [15:0]           i_reg_wdata,
   input  wire logic                  i_reg_wr,
   input  wire logic                  i_reg_rd,
   output logic [15:0]                o_reg_rdata
);

   // ==========================================================================
   // Pin synchronisers
   logic sclk_s1, sclk_s2, sclk_s3, cs_s1, cs_s2, cs_s3, din_s1, din_s2;
   logic sync_s1, sync_s2, sync_s3;

   // Two flops per pin; the third stage only serves edge detection.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         {sclk_s1, sclk_s2, sclk_s3} <= 3'h0;
         {cs_s1, cs_s2, cs_s3}       <= 3'h7;
         {din_s1, din_s2}            <= 2'h0;
         {sync_s1, sync_s2, sync_s3} <= 3'h7;
      end
      else
      begin
         {sclk_s1, sclk_s2, sclk_s3} <= {i_sclk, sclk_s1, sclk_s2};
         {cs_s1, cs_s2, cs_s3}       <= {i_cs_n, cs_s1, cs_s2};
         {din_s1, din_s2}            <= {i_din, din_s1};
         {sync_s1, sync_s2, sync_s3} <= {i_sync_rst_n, sync_s1, sync_s2};
      end
   end

   logic frame_on, cs_fall, cs_rise, sclk_rise, sclk_fall, sync_fall;
   assign frame_on  = ~cs_s2;
   assign cs_fall   = ~cs_s2 & cs_s3;
   assign cs_rise   = cs_s2 & ~cs_s3;
   assign sclk_rise = sclk_s2 & ~sclk_s3 & frame_on;
   assign sclk_fall = ~sclk_s2 & sclk_s3 & frame_on;
   assign sync_fall = ~sync_s2 & sync_s3;

   // ==========================================================================
   // Frame counters
   logic [15:0]        regs_q [64];
   logic [4:0]         bit_cnt_q, wlen_m1;
   logic [7:0]         word_cnt_q;
   logic [15:0]        rx_q, cmd_q, rx_word;
   logic               cmd_ok_q, word_done, half_done, frame_end, mread_q;
   logic [1:0]         wsel;

   assign wsel    = regs_q[`ADDR_MODE][9:8];
   assign wlen_m1 = (wsel == `WSEL_16) ? 5'd15 : (wsel == `WSEL_24) ? 5'd23 : 5'd31;
   assign rx_word   = {rx_q[14:0], din_s2};
   assign word_done = sclk_fall & (bit_cnt_q == wlen_m1);
   assign half_done = sclk_fall & (bit_cnt_q == 5'd15);
   assign frame_end = cs_rise & cmd_ok_q;

   // Bits are captured on falling SCLK; the count saturates on very long frames.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || cs_fall)
      begin
         bit_cnt_q  <= 5'h0;
         word_cnt_q <= 8'h0;
         rx_q       <= 16'h0;
         cmd_ok_q   <= 1'b0;
         cmd_q      <= 16'h0;
      end
      else if (sclk_fall)
      begin
         rx_q <= rx_word;
         if (word_cnt_q == 8'h0 && bit_cnt_q == 5'd15)
         begin
            cmd_q    <= rx_word;
            cmd_ok_q <= 1'b1;
         end
         if (word_done)
         begin
            bit_cnt_q <= 5'h0;
            if (word_cnt_q != 8'hFF)
               word_cnt_q <= word_cnt_q + 8'h01;
         end
         else
            bit_cnt_q <= bit_cnt_q + 5'h01;
      end
   end

   // ==========================================================================
   // Command decode
   logic locked_q, standby_q;
   cmd_kind_t cur_kind;

   function automatic cmd_kind_t decode(input logic [15:0] c, input logic lk);
      cmd_kind_t k;
      k = K_NULL;
      if (c == `CMD_RESET)             k = K_RESET;
      else if (c == `CMD_STANDBY)      k = K_STANDBY;
      else if (c == `CMD_WAKEUP)       k = K_WAKEUP;
      else if (c == `CMD_LOCK)         k = K_LOCK;
      else if (c == `CMD_UNLOCK)       k = K_UNLOCK;
      else if (c[15:13] == `PFX_REGISTER_READ_CMD)  k = K_REGISTER_READ_CMD;
      else if (c[15:13] == `PFX_REGISTER_WRITE_CMD)  k = K_REGISTER_WRITE_CMD;
      if (lk && k != K_REGISTER_READ_CMD && k != K_UNLOCK)
         k = K_NULL;
      return k;
   endfunction

   assign cur_kind = decode(cmd_q, locked_q);

   // ==========================================================================
   // Register writes from the link
   logic       wr_fire, wr_ok, dev_rst, frame_full;
   logic [5:0] wr_addr;
   logic [6:0] wr_cnt_q;

   assign wr_fire = half_done & cmd_ok_q & (cur_kind == K_REGISTER_WRITE_CMD) & (word_cnt_q != 8'h0)
                    & (word_cnt_q <= {1'b0, cmd_q[6:0]} + 8'h01);
   assign wr_addr = cmd_q[12:7] + word_cnt_q[5:0] - 6'h01;
   assign wr_ok      = wr_fire & (wr_addr >= `ADDR_MODE) & (wr_addr <= `REG_LAST);
   assign frame_full = word_cnt_q >= `FRAME_WORDS;
   assign dev_rst    = frame_end & (cur_kind == K_RESET) & frame_full;

   // Counts registers really changed in this frame.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || cs_fall)
         wr_cnt_q <= 7'h0;
      else if (wr_ok && wr_cnt_q != 7'h7F)
         wr_cnt_q <= wr_cnt_q + 7'h01;
   end

   // Register array; a link write beats a port write to the same cycle.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || dev_rst)
      begin
         for (int i = 0; i < 64; i++)
            regs_q[i] <= (i == 2) ? `MODE_RESET : (i == 3) ? `CLOCK_RESET : 16'h0000;
      end
      else if (wr_ok)
         regs_q[wr_addr] <= rx_word;
      else if (i_reg_wr && i_reg_addr >= `ADDR_MODE && i_reg_addr <= `REG_LAST)
         regs_q[i_reg_addr] <= i_reg_wdata;
   end

   // ==========================================================================
   // Output FIFOs, two samples per channel
   logic [23:0] head_w  [NCH];
   logic [23:0] coded_w [NCH];
   logic [1:0]  cnt_w   [NCH];
   logic [NCH-1:0] ready, pop;
   logic        fifo_clr;

   assign fifo_clr = sync_fall | dev_rst;

   generate
      for (genvar g = 0; g < NCH; g++)
      begin : g_ch
         logic [CONV_W-1:0] raw;
         logic [CONV_W-24:0] upper;
         logic [1:0]  cnt_q;
         logic [23:0] mem0_q, mem1_q;
         assign raw   = i_conv_data[g*CONV_W +: CONV_W];
         assign upper = raw[CONV_W-1:23];
         assign coded_w[g] = (upper == '0 || upper == '1) ? raw[23:0]
                             : raw[CONV_W-1] ? `CODE_MIN : `CODE_MAX;
         assign head_w[g] = mem0_q;
         assign cnt_w[g]  = cnt_q;
         // flag holds while any sample waits
         assign ready[g]  = cnt_q != 2'h0;
         assign pop[g]    = word_done & ~mread_q & (word_cnt_q == 8'(g + 1)) & ready[g];

         // two-entry store; a push into a full store drops the oldest sample.
         always_ff @(posedge i_clk)
         begin
            if (!i_rst_n || fifo_clr)
            begin
               cnt_q  <= 2'h0;
               mem0_q <= 24'h0;
               mem1_q <= 24'h0;
            end
            else if (i_conv_valid)
            begin
               if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop[g]))
                  mem0_q <= coded_w[g];
               else if (cnt_q == 2'h2 || pop[g])
                  mem0_q <= mem1_q;
               mem1_q <= coded_w[g];
               if (cnt_q == 2'h0 || (cnt_q == 2'h1 && !pop[g]))
                  cnt_q <= cnt_q + 2'h1;
            end
            else if (pop[g])
            begin
               mem0_q <= mem1_q;
               cnt_q  <= cnt_q - 2'h1;
            end
         end
      end
   endgenerate

   // ==========================================================================
   // Device state and answer selection
   rsp_kind_t   rsp_kind_q;
   logic [15:0] rsp_fixed_q, status;
   logic [5:0]  rd_addr_q;
   logic [6:0]  rd_n_q;

   assign status = {locked_q, 4'h0, regs_q[`ADDR_MODE][`MODE_RST_BIT], wsel, 8'(ready)};

   // Lock and standby change only when the frame closes.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n || dev_rst)
      begin
         locked_q  <= 1'b0;
         standby_q <= 1'b0;
      end
      else if (frame_end)
      begin
         unique case (cur_kind)
            K_STANDBY: standby_q <= 1'b1;
            K_WAKEUP:  standby_q <= 1'b0;
            K_LOCK:    locked_q  <= 1'b1;
            K_UNLOCK:  locked_q  <= 1'b0;
            default:   ;
         endcase
      end
   end

   // answer prepared for the next frame
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         rsp_kind_q  <= RSP_STATUS;
         rsp_fixed_q <= 16'h0;
         rd_addr_q   <= 6'h0;
         rd_n_q      <= 7'h0;
         mread_q     <= 1'b0;
      end
      else if (cs_rise)
      begin
         mread_q    <= 1'b0;
         rsp_kind_q <= RSP_FIXED;
         rd_addr_q  <= cmd_q[12:7];
         rd_n_q     <= cmd_q[6:0];
         unique case (cmd_ok_q ? cur_kind : K_NULL)
            K_RESET: rsp_fixed_q <= frame_full ? `RSP_RESET_ACK : `RSP_RESET_SHORT;
            K_STANDBY, K_WAKEUP, K_LOCK, K_UNLOCK: rsp_fixed_q <= cmd_q;
            K_REGISTER_READ_CMD:
            begin
               if (cmd_q[6:0] == 7'h0)
                  rsp_kind_q <= RSP_REG;
               else
                  mread_q <= 1'b1;
               rsp_fixed_q <= {`PFX_REGISTER_READ_CMD_HDR, cmd_q[12:0]};
            end
            K_REGISTER_WRITE_CMD: rsp_fixed_q <= {`PFX_REGISTER_WRITE_CMD_ACK, cmd_q[12:7],
                                    (wr_cnt_q == 7'h0) ? 7'h0 : wr_cnt_q - 7'h01};
            default: rsp_kind_q <= RSP_STATUS;
         endcase
      end
   end

   // Register view shared by link reads and the port.
   function automatic logic [15:0] reg_view(input logic [5:0] a);
      if (a == `ADDR_ID)
         return ID_VALUE;
      if (a == `ADDR_STATUS)
         return status;
      return (a <= `REG_LAST) ? regs_q[a] : 16'h0;
   endfunction

   // ==========================================================================
   // Outgoing word and serial output
   logic [31:0] cur_word;
   logic [2:0]  ch_sel;
   logic [23:0] ch_data;

   assign ch_sel  = word_cnt_q[2:0] - 3'h1;
   assign ch_data = head_w[ch_sel];

   // 32-bit words MSB aligned except sign-extended 32-bit data, which sits in the low 24 bits; the serialiser uses the top wlen bits.
   always_comb
   begin
      cur_word = 32'h0;
      if (word_cnt_q == 8'h0)
      begin
         unique case (rsp_kind_q)
            RSP_STATUS: cur_word = {status, 16'h0};
            RSP_REG:    cur_word = {reg_view(rd_addr_q), 16'h0};
            default:    cur_word = {rsp_fixed_q, 16'h0};
         endcase
      end
      else if (mread_q)
      begin
         if (word_cnt_q <= {1'b0, rd_n_q} + 8'h01)
            cur_word = {reg_view(rd_addr_q + word_cnt_q[5:0] - 6'h01), 16'h0};
      end
      else if (word_cnt_q <= 8'(NCH))
      begin
         unique case (wsel)
            `WSEL_16:      cur_word = {ch_data[23:8], 16'h0};
            `WSEL_32_SEXT: cur_word = {{8{ch_data[23]}}, ch_data};
            default:       cur_word = {ch_data, 8'h0};
         endcase
      end
   end

   // Bits launch on rising SCLK; the line is driven only inside a frame.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         o_dout    <= 1'b0;
         o_dout_oe <= 1'b0;
      end
      else
      begin
         o_dout_oe <= frame_on;
         if (cs_fall)
            o_dout <= 1'b0;
         else if (sclk_rise)
            o_dout <= cur_word[5'd31 - bit_cnt_q];
      end
   end

   // ==========================================================================
   // Ready line, realign strobe and register port
   logic [3:0] pulse_cnt_q;
   logic       fmt_pulse;

   assign fmt_pulse = regs_q[`ADDR_MODE][`MODE_FMT_BIT];
   assign o_standby = standby_q;

   // level format may rise briefly between reads; hosts must not rely on it.
   always_ff @(posedge i_clk)
   begin
      if (!i_rst_n)
      begin
         pulse_cnt_q    <= 4'h0;
         o_data_ready_n <= 1'b1;
         o_realign      <= 1'b0;
         o_reg_rdata    <= 16'h0;
      end
      else
      begin
         if (i_conv_valid)
            pulse_cnt_q <= 4'(`READY_PULSE_CYC);
         else if (pulse_cnt_q != 4'h0)
            pulse_cnt_q <= pulse_cnt_q - 4'h1;
         o_data_ready_n <= fmt_pulse ? (pulse_cnt_q == 4'h0) : ~|ready;
         o_realign      <= sync_fall;
         o_reg_rdata    <= i_reg_rd ? reg_view(i_reg_addr) : 16'h0;
      end
   end

   // ==========================================================================
   // Checks
   AST_CLIP_POS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (!i_conv_data[CONV_W-1] && i_conv_data[CONV_W-2:23] != '0) |-> coded_w[0] == `CODE_MAX)
      else $error("positive overrange not clipped");
   AST_CLIP_NEG: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_conv_data[CONV_W-1] && i_conv_data[CONV_W-2:23] != '1) |-> coded_w[0] == `CODE_MIN)
      else $error("negative overrange not clipped");
   AST_TWOS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_conv_data[CONV_W-1:23] == '0) |-> coded_w[0] == i_conv_data[23:0])
      else $error("in-range code altered");
   AST_FIFO_DEPTH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (i_conv_valid && !pop[0] && !fifo_clr && cnt_w[0] != 2'h0) |=> cnt_w[0] == 2'h2)
      else $error("fifo does not fill to two");
   AST_READY_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (cnt_w[0] == 2'h2 && pop[0] && !i_conv_valid && !fifo_clr) |=> ready[0])
      else $error("ready dropped with a sample left");
   AST_SYNC_CLEAR: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      sync_fall |=> (ready == '0 && o_realign) ##1 o_realign == 1'b0)
      else $error("sync did not empty fifo");
   AST_NULL_STATUS: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (frame_end && cmd_q == `CMD_NULL) |=> rsp_kind_q == RSP_STATUS && $stable(locked_q))
      else $error("null command not answered with status");
   AST_INVALID: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (frame_end && cmd_q == 16'hFFFF) |=> rsp_kind_q == RSP_STATUS)
      else $error("invalid command not treated as null");
   AST_RESET_ACK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      dev_rst |=> rsp_fixed_q == `RSP_RESET_ACK && regs_q[`ADDR_MODE] == `MODE_RESET)
      else $error("reset frame not acknowledged");
   AST_RESET_SHORT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (frame_end && cur_kind == K_RESET && !frame_full) |=> rsp_fixed_q == `RSP_RESET_SHORT)
      else $error("short reset frame misanswered");
   AST_LOCK_BLOCK: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (frame_end && locked_q && cmd_q == `CMD_STANDBY) |=> $stable(standby_q))
      else $error("locked interface accepted standby");
   AST_REGISTER_READ_CMD_SINGLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
      (frame_end && cur_kind == K_REGISTER_READ_CMD && cmd_q[6:0] == 7'h0)
      |=> rsp_kind_q == RSP_REG && !mread_q)
      else $error("single read not answered directly");
   COV_SYNC: cover property (@(posedge i_clk) disable iff (!i_rst_n) sync_fall && ready != '0);
   COV_RESET: cover property (@(posedge i_clk) disable iff (!i_rst_n) dev_rst);
   COV_MREAD: cover property (@(posedge i_clk) disable iff (!i_rst_n) mread_q && sclk_rise);

endmodule

// ===== tb/adc_spi_command_and_output_path_tb_top.sv
// Purpose: Self-checking bench for the command path and conversion output.
// Assumes: Default 24-bit words; level ready format unless a test changes it.
// Notes:   Each test is a task that drives and judges before returning.
`timescale 1ns/1ps
module adc_spi_command_and_output_path_tb_top;
   // ====================
   // Stimulus and observed signals
   logic         i_clk   = 1'b0;
   logic         i_rst_n = 1'b0;
   logic         sync_n  = 1'b1;
   logic         cv      = 1'b0;
   logic [207:0] cd      = '0;
   logic [5:0]   ra      = 6'h00;
   logic [15:0]  rw      = 16'h0000;
   logic         wr      = 1'b0;
   logic         rd      = 1'b0;
   logic         sclk, cs_n, din, dout, oe, rdy_n, stby, realign;
   logic [15:0]  rdat;
   int           n_mismatch = 0;
   int           cmp_count  = 0;

   always #12.5 i_clk = ~i_clk;

   adc_spi_cmd dut (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_din(din), .o_dout(dout), .o_dout_oe(oe), .o_data_ready_n(rdy_n),
      .i_sync_rst_n(sync_n), .i_conv_valid(cv), .i_conv_data(cd), .o_standby(stby),
      .o_realign(realign), .i_reg_addr(ra), .i_reg_wdata(rw), .i_reg_wr(wr),
      .i_reg_rd(rd), .o_reg_rdata(rdat));
   // A released data line shows the inverse, so a missing drive enable corrupts the answer.
   spi_host_model u_host (.i_clk(i_clk), .i_dout(oe ? dout : ~dout), .o_sclk(sclk),
      .o_cs_n(cs_n), .o_din(din));

   // ====================
   // Shared tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic register_read_cmd(input logic [5:0] a, input logic [15:0] exp);
      @(posedge i_clk) rd <= 1'b1;
      ra <= a;
      @(posedge i_clk) rd <= 1'b0;
      #1 chk(rdat, exp);
   endtask

   task automatic register_write_cmd(input logic [5:0] a, input logic [15:0] d);
      @(posedge i_clk) wr <= 1'b1;
      ra <= a;
      rw <= d;
      @(posedge i_clk) wr <= 1'b0;
   endtask

   // Command goes in the top 16 bits of word 0; word 1 carries w1, other words carry zeros.
   task automatic run(input logic [15:0] c, input int nw, input logic [23:0] w1 = '0);
      for (int i = 0; i < 16; i++)
         u_host.tx[i] = '0;
      u_host.tx[0] = {c, 8'h00};
      u_host.tx[1] = w1;
      u_host.frame(nw);
   endtask

   task automatic push(input logic [207:0] d);
      @(posedge i_clk) cv <= 1'b1;
      cd <= d;
      @(posedge i_clk) cv <= 1'b0;
   endtask

   // ====================
   // Tests
   task automatic t_regs();
      register_read_cmd(6'h02, 16'h0510);
      register_read_cmd(6'h3F, 16'h0000);
      register_write_cmd(6'h03, 16'h1234);
      register_write_cmd(6'h01, 16'hFFFF);
      register_read_cmd(6'h03, 16'h1234);
      register_read_cmd(6'h01, 16'h0500);
      $display("t_regs done");
   endtask

   task automatic t_data();
      logic [23:0] e [8] = '{24'h7FFFFF, 24'h000001, 24'h000000, 24'hFFFFFF,
                             24'h800000, 24'h7FFFFF, 24'h800000, 24'h000000};
      push({26'h0, 26'h3800000, 26'h07FFFFF, 26'h2000000, 26'h3FFFFFF, 26'h0, 26'h1,
            26'h1000000});
      push(cd);
      chk(rdy_n, 1'b0);
      run(16'h0000, 10);
      for (int i = 1; i < 9; i++)
         chk(u_host.rx[i], e[i-1]);
      chk(rdy_n, 1'b0);
      run(16'h0000, 10);
      chk(u_host.rx[0], 24'h05FF00);
      chk(rdy_n, 1'b1);
      $display("t_data done");
   endtask

   task automatic t_sync();
      logic seen = 1'b0;
      push(cd);
      @(posedge i_clk) sync_n <= 1'b0;
      repeat (10)
      begin
         @(posedge i_clk);
         #1 seen |= realign;
      end
      @(posedge i_clk) sync_n <= 1'b1;
      chk(seen, 1'b1);
      chk(rdy_n, 1'b1);
      $display("t_sync done");
   endtask

   task automatic t_cmds();
      run(16'h0555, 10);
      run(16'h0022, 10);
      chk(u_host.rx[0], 24'h055500);
      run(16'h0000, 10);
      chk(u_host.rx[0], 24'h850000);
      chk(stby, 1'b0);
      run(16'h0655, 10);
      chk(u_host.rx[0], 24'h850000);
      run(16'h0022, 10);
      chk(u_host.rx[0], 24'h065500);
      chk(stby, 1'b1);
      run(16'h0033, 10);
      chk(u_host.rx[0], 24'h002200);
      run(16'hFFFF, 10);
      chk(u_host.rx[0], 24'h003300);
      chk(stby, 1'b0);
      run(16'h0000, 10);
      chk(u_host.rx[0], 24'h050000);
      $display("t_cmds done");
   endtask

   task automatic t_rw();
      run({3'h5, 6'h02, 7'h00}, 10);
      run({3'h5, 6'h02, 7'h01}, 10);
      chk(u_host.rx[0], 24'h051000);
      run({3'h3, 6'h3E, 7'h01}, 10);
      chk(u_host.rx[0], {3'h7, 6'h02, 7'h01, 8'h00});
      chk(u_host.rx[2], 24'h123400);
      u_host.tx[1] = 24'h000000;
      run(16'h0000, 10);
      $display("t_rw done");
   endtask

   task automatic t_wr();
      run({3'h3, 6'h3E, 7'h01}, 10, 24'hABCD00);
      run(16'h0000, 10);
      chk(u_host.rx[0], 24'h5F0000);
      register_read_cmd(6'h3E, 16'hABCD);
      $display("t_wr done");
   endtask

   task automatic t_reset();
      register_write_cmd(6'h02, 16'h0511);
      // Pulse format: a short low pulse per sample even while samples wait.
      push(cd);
      @(posedge i_clk);
      #1 chk(rdy_n, 1'b0);
      repeat (3) @(posedge i_clk);
      #1 chk(rdy_n, 1'b1);
      run(16'h0011, 3);
      run(16'h0000, 10);
      chk(u_host.rx[0], 24'h001100);
      register_read_cmd(6'h02, 16'h0511);
      run(16'h0011, 10);
      repeat (40) @(posedge i_clk);
      run(16'h0000, 10);
      chk(u_host.rx[0], 24'hFF2800);
      register_read_cmd(6'h02, 16'h0510);
      $display("t_reset done");
   endtask

   // ====================
   // Verdict and run control
   task automatic test_done();
      $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // The run needs about 37000 clocks; a hang is cut off well past that.
   initial
   begin
      repeat (95000) @(posedge i_clk);
      n_mismatch++;
      test_done();
   end

   // Main sequence after a two-cycle reset.
   initial
   begin
      repeat (2) @(posedge i_clk);
      i_rst_n <= 1'b1;
      repeat (3) @(posedge i_clk);
      chk(oe, 1'b0);
      chk(stby, 1'b0);
      t_regs();
      t_data();
      t_sync();
      t_cmds();
      t_rw();
      t_wr();
      t_reset();
      test_done();
   end
endmodule

// ===== tb/spi_host_model.sv
// Purpose: Host controller model that runs framed transfers on the serial link.
// Assumes: 24-bit words; the link clock idles low with a half period of four clocks.
// Notes:   Data in is inverted between frames so that no stale level lingers.
`timescale 1ns/1ps
module spi_host_model
(
   // System clock
   input  wire logic i_clk,
   // Link pins
   input  wire logic i_dout,
   output logic      o_sclk,
   output logic      o_cs_n,
   output logic      o_din
);
   // ====================
   // Frame engine
   logic [23:0] tx [16];
   logic [23:0] rx [16];

   // Idle levels before the first frame.
   initial
   begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_din  = 1'b0;
   end

   // Four clocks is the shortest half period that the block still samples safely.
   task automatic half();
      repeat (4) @(posedge i_clk);
   endtask

   // Shift out tx words MSB first; sample the answer on each falling link edge.
   task automatic frame(input int nw);
      o_cs_n <= 1'b0;
      half();
      for (int i = 0; i < nw; i++)
      begin
         for (int b = 23; b >= 0; b--)
         begin
            o_din  <= tx[i][b];
            o_sclk <= 1'b1;
            half();
            o_sclk   <= 1'b0;
            rx[i][b] = i_dout;
            half();
         end
      end
      o_cs_n <= 1'b1;
      o_din  <= ~o_din;
      repeat (8) @(posedge i_clk);
   endtask
endmodule
